// ===== tb/psbt_host.sv
// host model: drives link clock, select, data and write mask
// assumes mclk_i at 10 ns; link clock half period is four mclk cycles
`timescale 1ns/1ps
`default_nettype none
module psbt_host (
	input wire logic mclk_i
);
	logic ck = 0, cs_n = 1, s = 0, s_oe = 0;
	logic [7:0] dq = 8'h00;
	task t(input logic [7:0] d, input logic m, input logic oe);
		dq = d;
		s = m;
		s_oe = oe;
		repeat (2) @(negedge mclk_i);
		ck = ~ck;
		repeat (2) @(negedge mclk_i);
	endtask
	task xfer(input logic [47:0] ca, input int lat, input logic [31:0] d, input logic [3:0] mk,
		input int n);
		@(negedge mclk_i);
		cs_n = 0;
		repeat (4) @(negedge mclk_i);
		for (int i = 5; i >= 0; i--) t(ca[i*8+:8], 1'b1, 1'b0);
		repeat (2 * lat) t(8'h00, 1'b0, lat > 0 && !ca[47]);
		for (int i = n - 1; i >= 0; i--) t(d[i*8+:8], mk[i], lat > 0 && !ca[47]);
		cs_n = 1;
		s_oe = 0;
		dq = ~dq;
	endtask
endmodule
`default_nettype wire

// ===== tb/psbt_port_assertions.sv
// checker for the transaction port pins and write stream
// assumes it is bound to every psbt_port instance
`timescale 1ns/1ps
`default_nettype none
module psbt_chk (
	input wire logic mclk_i, rst_i, cs_n_i, dq_oe_o, read_write_strobe_mask_oe_o, wr_valid_o,
	input wire logic wr_ready_i,
	input wire logic [15:0] first_configuration_register_o,
	input wire psbt_pkg::psbt_wr_s wr_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_drv; $fell(cs_n_i) |-> ##[1:12] read_write_strobe_mask_oe_o; endproperty
	a_drv: assert property (p_drv) else $error("strobe not driven in command phase");
	property p_pair; dq_oe_o |-> read_write_strobe_mask_oe_o; endproperty
	a_pair: assert property (p_pair) else $error("read data without strobe");
	property p_idq; cs_n_i [*8] |-> !dq_oe_o; endproperty
	a_idq: assert property (p_idq) else $error("data driven while deselected");
	property p_irw; cs_n_i [*8] |-> !read_write_strobe_mask_oe_o; endproperty
	a_irw: assert property (p_irw) else $error("strobe driven while deselected");
	property p_hold; wr_valid_o && !wr_ready_i |=> wr_valid_o; endproperty
	a_hold: assert property (p_hold) else $error("write word dropped");
	property p_keep; wr_valid_o && !wr_ready_i |=> $stable(wr_o); endproperty
	a_keep: assert property (p_keep) else $error("write word changed");
	property p_rst; $fell(rst_i) |-> first_configuration_register_o == psbt_pkg::CFG0_RST; endproperty
	a_rst: assert property (p_rst) else $error("bad config reset value");
	property p_cfg; cs_n_i [*8] |=> $stable(first_configuration_register_o); endproperty
	a_cfg: assert property (p_cfg) else $error("config changed while idle");
	cover property (wr_valid_o && wr_ready_i);
	cover property ($fell(cs_n_i));
	cover property (!$stable(first_configuration_register_o));
endmodule
bind psbt_port psbt_chk chk (.mclk_i, .rst_i, .cs_n_i, .dq_oe_o, .read_write_strobe_mask_oe_o,
	.wr_valid_o, .wr_ready_i, .first_configuration_register_o, .wr_o);
`default_nettype wire

// ===== tb/psbt_port_tb.sv
// self-checking bench for the transaction port
// assumes the host model drives the link and the bench plays the array
`timescale 1ns/1ps
`default_nettype none
module psbt_port_tb;
	logic mclk_i = 0, rst_i = 1, wr_ready_i = 0, rd_valid_i = 0, refresh_busy_i = 0, strobe_pin;
	logic ls = 0;
	logic [7:0] rb_q[$];
	logic [7:0] lfsr = 8'h41, dq_o;
	logic [15:0] rd_data_i = 16'h0000, first_configuration_register_o;
	logic [31:0] d;
	logic dq_oe_o, read_write_strobe_mask_o, read_write_strobe_mask_oe_o, overrun_o, wr_valid_o, rd_req_o;
	logic [psbt_pkg::ADDR_W-1:0] rd_addr_o;
	psbt_pkg::psbt_wr_s wr_o, exp_q[$];
	int fail_count = 0, tests_run = 0, cyc = 0;
	psbt_host h (.mclk_i);
	assign strobe_pin = read_write_strobe_mask_oe_o ? read_write_strobe_mask_o : h.s_oe ? h.s : ~h.s;
	psbt_port dut (.mclk_i, .rst_i, .link_ck_i(h.ck), .cs_n_i(h.cs_n), .dq_i(h.dq), .dq_o, .dq_oe_o,
		.read_write_strobe_mask_i(strobe_pin), .read_write_strobe_mask_o, .read_write_strobe_mask_oe_o,
		.refresh_busy_i, .first_configuration_register_o, .overrun_o, .wr_valid_o, .wr_ready_i, .wr_o,
		.rd_req_o, .rd_addr_o, .rd_valid_i, .rd_data_i);
	initial forever #5 mclk_i = ~mclk_i;
	function logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task cmp(input string n, input logic [39:0] e, input logic [39:0] g);
		tests_run++;
		if (e !== g)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task give_verdict;
		$display("fail_count %0d tests_run %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(negedge mclk_i)
	begin
		lfsr <= nx(lfsr);
		wr_ready_i <= lfsr[0];
		rd_valid_i <= rd_req_o;
		rd_data_i <= {lfsr, ~lfsr};
	end
	always @(posedge mclk_i)
	begin
		if (wr_valid_o === 1'b1 && wr_ready_i) cmp("word", exp_q.pop_front(), wr_o);
		if (dq_oe_o === 1'b1 && read_write_strobe_mask_o !== ls) cmp("rbyte", rb_q.pop_front(), dq_o);
		ls <= read_write_strobe_mask_o;
		if (++cyc == 20000)
		begin
			fail_count++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i) rst_i = 0;
		h.xfer(48'h600001000000, 0, 32'h0000004B, 4'h0, 2);
		repeat (20) @(negedge mclk_i);
		cmp("cfg", 40'h4B, first_configuration_register_o);
		refresh_busy_i = 1;
		rb_q.push_back(8'h00);
		rb_q.push_back(8'h4B);
		h.xfer(48'hC00001000000, 8, 32'h0, 4'h0, 2);
		refresh_busy_i = 0;
		repeat (20) @(negedge mclk_i);
		d = {lfsr, ~lfsr, lfsr ^ 8'h5A, 8'hC3};
		exp_q.push_back({22'h3FFFFF, d[31:16], 2'b11});
		exp_q.push_back({22'h000000, d[15:0], 2'b01});
		h.xfer(48'h2007FFFF0007, 4, d, 4'b0010, 4);
		repeat (200) @(negedge mclk_i);
		cmp("left", 40'h0, exp_q.size());
		cmp("rleft", 40'h0, rb_q.size());
		cmp("overrun", 40'h0, overrun_o);
		give_verdict;
	end
endmodule
`default_nettype wire

// ===== verilog/psbt_pkg.sv
// constants, field positions and carrier types for the burst transaction port
// assumes a 100 MHz mclk_i and a link clock sampled as an ordinary input
package psbt_pkg;
	// command-address word layout
	localparam int CMD_W         = 48;
	localparam int CMD_DIR       = 47;
	localparam int CMD_SPACE     = 46;
	localparam int CMD_BURST     = 45;
	localparam int CMD_UPPER_LSB = 16;
	localparam int CMD_LOWER_W   = 3;
	localparam int CMD_SEL_CFG   = 24;
	localparam int CMD_SEL_IDX   = 0;
	localparam logic [2:0] CMD_LAST_EDGE = 3'h5;

	// word address width of the array
	localparam int ADDR_W = 22;

	// first configuration register fields
	localparam int LAT_LSB  = 4;
	localparam int LAT_W    = 4;
	localparam int BLEN_LSB = 0;
	localparam int BLEN_W   = 2;
	localparam int HYB_BIT  = 2;
	localparam logic [ADDR_W-1:0] BLEN_MIN = 22'h000008;

	// reset values
	localparam logic [15:0] CFG0_RST = 16'h0043;
	localparam logic [15:0] CFG1_RST = 16'h0000;
	// identification words: arbitrary neutral values
	localparam logic [15:0] ID0_VAL = 16'h0A5A;
	localparam logic [15:0] ID1_VAL = 16'h0001;

	// one array write word
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0]       data;
		logic [1:0]        be;
	} psbt_wr_s;

	typedef enum {
		ST_IDLE,
		ST_CMD,
		ST_LAT,
		ST_RD,
		ST_WR,
		ST_REGWR,
		ST_HOLD
	} psbt_state_e;
endpackage

// ===== verilog/psbt_port.sv
// pseudo-static memory transaction port: link pins in, array read/write ports out
// assumes link pins are asynchronous to mclk_i and the link clock is much slower
//
// What this block does
// - command-address bit 47 set means read, clear means write.
// - command-address bit 46 clear targets the memory array.
// - command-address bit 46 set targets register space.
// - command-address bit 45 picks linear (set) or wrapped (clear) burst.
// - upper bits give row and column, low bits pick word in row.
// - strobe high during command phase doubles latency, low gives single latency.
// - latency count comes from bits 7..4 of first configuration register.
// - after latency, read strobe toggles with each edge-aligned data byte.
// - read data flows while clocked; strobe held low inserts wait between words.
// - wrapped reads wrap in burst length; linear reads run on sequentially.
// - array write takes upper byte on rising, lower byte on falling edge.
// - memory drives strobe during command phase; keeps driving it for reads, releases it for writes.
// - write strobe high masks the byte, low stores it.
// - no wait states anywhere in write data.
// - hybrid wrap wraps once then goes linear from next boundary.
// - linear write past last address continues at address zero.
// - command-address phase takes the first three link clocks.
// - register writes have zero latency; strobe released after command phase.
`timescale 1ns/1ps
`default_nettype none

module psbt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	// filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;

	assign out_valid_o = wr_ptr != rd_ptr;
	assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge mclk_i)
	begin
		if (in_valid_i && in_ready_o)
		begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid_i && in_ready_o)
			begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid_o && out_ready_i)
			begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module psbt_port #(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        rst_i,
	// link pins
	input  wire logic                        link_ck_i,
	input  wire logic                        cs_n_i,
	input  wire logic [7:0]                  dq_i,
	output logic [7:0]                       dq_o,
	output logic                             dq_oe_o,
	input  wire logic                        read_write_strobe_mask_i,
	output logic                             read_write_strobe_mask_o,
	output logic                             read_write_strobe_mask_oe_o,
	// status and configuration
	input  wire logic                        refresh_busy_i,
	output logic [15:0]                      first_configuration_register_o,
	output logic                             overrun_o,
	// array write stream
	output logic                             wr_valid_o,
	input  wire logic                        wr_ready_i,
	output psbt_pkg::psbt_wr_s               wr_o,
	// array read port
	output logic                             rd_req_o,
	output logic [psbt_pkg::ADDR_W-1:0]      rd_addr_o,
	input  wire logic                        rd_valid_i,
	input  wire logic [15:0]                 rd_data_i
);
	localparam int AW = psbt_pkg::ADDR_W;
	localparam int WW = $bits(psbt_pkg::psbt_wr_s);
	localparam int CW = 7;
	localparam logic [AW-1:0] ADDR_ONE = {{(AW - 1){1'b0}}, 1'b1};
	localparam logic [CW-1:0] CNT_ONE  = {{(CW - 1){1'b0}}, 1'b1};

	// synchronised pins and link clock edges
	logic                       cs_s1;
	logic                       cs_s2;
	logic                       ck_s1;
	logic                       ck_s2;
	logic                       ck_s3;
	logic                       rw_s1;
	logic                       rw_s2;
	logic [7:0]                 dq_s1;
	logic [7:0]                 dq_s2;
	logic                       sel;
	logic                       ck_edge;
	// transaction decode
	psbt_pkg::psbt_state_e      state;
	logic [psbt_pkg::CMD_W-1:0] cmd;
	logic [psbt_pkg::CMD_W-1:0] cmd_next;
	logic                       cmd_done;
	logic [CW-1:0]              edge_cnt;
	logic [CW-1:0]              lat_edges;
	logic                       dbl;
	logic                       is_read;
	logic                       is_reg;
	logic                       is_linear;
	logic                       hybrid;
	// burst position
	logic [AW-1:0]              cmd_addr;
	logic [AW-1:0]              addr;
	logic [AW-1:0]              start_addr;
	logic [AW-1:0]              blen;
	logic [AW-1:0]              wrap_mask;
	logic [AW-1:0]              word_cnt;
	logic [AW-1:0]              next_addr;
	logic                       hyb_lin;
	logic                       byte_odd;
	logic                       adv;
	// data path
	logic [15:0]                cfg0;
	logic [15:0]                cfg1;
	logic [15:0]                reg_word;
	logic [15:0]                cur_word;
	logic [15:0]                rd_buf;
	logic                       rd_have;
	logic [7:0]                 lo_byte;
	logic [7:0]                 upper_byte;
	logic                       upper_keep;
	logic                       push;
	psbt_pkg::psbt_wr_s         push_word;
	logic                       fifo_ready;
	logic [WW-1:0]              fifo_out;

	assign sel       = !cs_s2;
	assign ck_edge   = ck_s2 != ck_s3;
	assign cmd_next  = {cmd[psbt_pkg::CMD_W-9:0], dq_s2};
	assign cmd_done  = (state == psbt_pkg::ST_CMD) && ck_edge
		&& (edge_cnt == CW'(psbt_pkg::CMD_LAST_EDGE));
	assign cmd_addr  = {cmd_next[psbt_pkg::CMD_UPPER_LSB +: AW - psbt_pkg::CMD_LOWER_W],
		cmd_next[psbt_pkg::CMD_LOWER_W-1:0]};
	assign is_read   = cmd[psbt_pkg::CMD_DIR];
	assign is_reg    = cmd[psbt_pkg::CMD_SPACE];
	assign is_linear = cmd[psbt_pkg::CMD_BURST];
	assign hybrid    = cfg0[psbt_pkg::HYB_BIT];
	assign blen      = psbt_pkg::BLEN_MIN << cfg0[psbt_pkg::BLEN_LSB +: psbt_pkg::BLEN_W];
	assign wrap_mask = blen - ADDR_ONE;
	assign lat_edges = dbl ? {1'b0, cfg0[psbt_pkg::LAT_LSB +: psbt_pkg::LAT_W], 2'b00}
		: {2'b00, cfg0[psbt_pkg::LAT_LSB +: psbt_pkg::LAT_W], 1'b0};
	assign cur_word  = is_reg ? reg_word : rd_buf;
	// a read word start with nothing fetched holds the strobe low
	assign adv       = ck_edge && ((state == psbt_pkg::ST_WR) || (state == psbt_pkg::ST_REGWR)
		|| ((state == psbt_pkg::ST_RD) && (byte_odd || is_reg || rd_have)));
	assign first_configuration_register_o = cfg0;
	assign wr_o      = fifo_out;

	always_comb
	begin
		if (is_linear || hyb_lin)
			next_addr = addr + ADDR_ONE;
		else if (hybrid && (word_cnt == wrap_mask))
			next_addr = (start_addr & ~wrap_mask) + blen;
		else
			next_addr = (addr & ~wrap_mask) | ((addr + ADDR_ONE) & wrap_mask);
	end

	always_comb
	begin
		if (cmd[psbt_pkg::CMD_SEL_CFG])
			reg_word = cmd[psbt_pkg::CMD_SEL_IDX] ? cfg1 : cfg0;
		else
			reg_word = cmd[psbt_pkg::CMD_SEL_IDX] ? psbt_pkg::ID1_VAL : psbt_pkg::ID0_VAL;
	end

	// two-flop synchronisers, idle levels at reset
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			rw_s1 <= 1'b0;
			rw_s2 <= 1'b0;
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end
		else
		begin
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			ck_s1 <= link_ck_i;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			rw_s1 <= read_write_strobe_mask_i;
			rw_s2 <= rw_s1;
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
		end
	end

	// transaction sequencing
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || !sel)
		begin
			state    <= psbt_pkg::ST_IDLE;
			edge_cnt <= '0;
		end
		else
		begin
			unique case (state)
				psbt_pkg::ST_IDLE:
					state <= psbt_pkg::ST_CMD;
				psbt_pkg::ST_CMD:
				begin
					if (cmd_done)
					begin
						edge_cnt <= '0;
						if (cmd_next[psbt_pkg::CMD_SPACE] && !cmd_next[psbt_pkg::CMD_DIR])
							state <= psbt_pkg::ST_REGWR;
						else if (lat_edges == '0)
							state <= cmd_next[psbt_pkg::CMD_DIR] ? psbt_pkg::ST_RD : psbt_pkg::ST_WR;
						else
							state <= psbt_pkg::ST_LAT;
					end
					else if (ck_edge)
						edge_cnt <= edge_cnt + CNT_ONE;
				end
				psbt_pkg::ST_LAT:
				begin
					if (ck_edge && (edge_cnt == lat_edges - CNT_ONE))
						state <= is_read ? psbt_pkg::ST_RD : psbt_pkg::ST_WR;
					else if (ck_edge)
						edge_cnt <= edge_cnt + CNT_ONE;
				end
				psbt_pkg::ST_REGWR:
				begin
					if (adv && byte_odd)
						state <= psbt_pkg::ST_HOLD;
				end
				psbt_pkg::ST_RD, psbt_pkg::ST_WR, psbt_pkg::ST_HOLD:
				begin
				end
			endcase
		end
	end

	// command capture and refresh latency indication
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			cmd <= '0;
			dbl <= 1'b0;
		end
		else if (state == psbt_pkg::ST_IDLE)
			dbl <= refresh_busy_i;
		else if ((state == psbt_pkg::ST_CMD) && ck_edge)
			cmd <= cmd_next;
	end

	// burst address and byte position
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || cmd_done)
		begin
			byte_odd   <= 1'b0;
			hyb_lin    <= 1'b0;
			word_cnt   <= '0;
			addr       <= rst_i ? '0 : cmd_addr;
			start_addr <= rst_i ? '0 : cmd_addr;
		end
		else if (adv)
		begin
			byte_odd <= !byte_odd;
			if (byte_odd)
			begin
				addr     <= next_addr;
				word_cnt <= word_cnt + ADDR_ONE;
				if (hybrid && !is_linear && (word_cnt == wrap_mask))
					hyb_lin <= 1'b1;
			end
		end
	end

	// write bytes: first on the rising link edge, second on the falling
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			upper_byte <= 8'h00;
			upper_keep <= 1'b0;
			push       <= 1'b0;
			push_word  <= '0;
		end
		else
		begin
			push <= 1'b0;
			if (adv && !byte_odd)
			begin
				upper_byte <= dq_s2;
				upper_keep <= !rw_s2;
			end
			if ((state == psbt_pkg::ST_WR) && adv && byte_odd)
			begin
				push           <= 1'b1;
				push_word.addr <= addr;
				push_word.data <= {upper_byte, dq_s2};
				push_word.be   <= {upper_keep, !rw_s2};
			end
		end
	end

	// configuration registers, written as whole words
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			cfg0 <= psbt_pkg::CFG0_RST;
			cfg1 <= psbt_pkg::CFG1_RST;
		end
		else if ((state == psbt_pkg::ST_REGWR) && adv && byte_odd && cmd[psbt_pkg::CMD_SEL_CFG])
		begin
			if (cmd[psbt_pkg::CMD_SEL_IDX])
				cfg1 <= {upper_byte, dq_s2};
			else
				cfg0 <= {upper_byte, dq_s2};
		end
	end

	// read data onto the link, one byte per link edge
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			dq_o      <= 8'h00;
			dq_oe_o   <= 1'b0;
			lo_byte   <= 8'h00;
			rd_req_o  <= 1'b0;
			rd_addr_o <= '0;
		end
		else
		begin
			rd_req_o <= 1'b0;
			if (!sel)
				dq_oe_o <= 1'b0;
			else if (cmd_done && cmd_next[psbt_pkg::CMD_DIR] && !cmd_next[psbt_pkg::CMD_SPACE])
			begin
				rd_req_o  <= 1'b1;
				rd_addr_o <= cmd_addr;
			end
			else if ((state == psbt_pkg::ST_RD) && adv)
			begin
				dq_oe_o <= 1'b1;
				if (!byte_odd)
				begin
					dq_o    <= cur_word[15:8];
					lo_byte <= cur_word[7:0];
					if (!is_reg)
					begin
						rd_req_o  <= 1'b1;
						rd_addr_o <= next_addr;
					end
				end
				else
					dq_o <= lo_byte;
			end
		end
	end

	// fetched array word; an arriving word wins over its consumption
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rd_buf  <= 16'h0000;
			rd_have <= 1'b0;
		end
		else if (rd_valid_i && sel)
		begin
			rd_buf  <= rd_data_i;
			rd_have <= 1'b1;
		end
		else if (!sel || ((state == psbt_pkg::ST_RD) && adv && !byte_odd))
			rd_have <= 1'b0;
	end

	// strobe: latency flag in the command phase, toggling read strobe later
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || !sel)
		begin
			read_write_strobe_mask_o    <= 1'b0;
			read_write_strobe_mask_oe_o <= 1'b0;
		end
		else if (state == psbt_pkg::ST_IDLE)
		begin
			read_write_strobe_mask_oe_o <= 1'b1;
			read_write_strobe_mask_o    <= refresh_busy_i;
		end
		else if (cmd_done)
		begin
			read_write_strobe_mask_oe_o <= cmd_next[psbt_pkg::CMD_DIR];
			read_write_strobe_mask_o    <= 1'b0;
		end
		else if ((state == psbt_pkg::ST_RD) && adv)
			read_write_strobe_mask_o <= !read_write_strobe_mask_o;
	end

	// sticky flag: a write word met a full buffer
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			overrun_o <= 1'b0;
		else if (push && !fifo_ready)
			overrun_o <= 1'b1;
	end

	psbt_fifo #(
		.WIDTH(WW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.in_data_i   (push_word),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i),
		.out_data_o  (fifo_out)
	);
endmodule
`default_nettype wire
